/* verilog/rws_cfg.svh */
// timing, offsets and reset values of the reset and watchdog sequencer
`ifndef RWS_CFG_SVH
`define RWS_CFG_SVH
`define RWS_CLK_MHZ 200
`define RWS_HALT_MS 50
`define RWS_HALT_CYC (`RWS_HALT_MS * 1000 * `RWS_CLK_MHZ)
`define RWS_OFF_INTERVAL 4'h2
`define RWS_OFF_RESTART 4'h3
`define RWS_OFF_CAUSE 4'h4
`define RWS_OFF_STATUS 4'h5
`define RWS_SEL_LO_BIT 0
`define RWS_SEL_HI_BIT 1
`define RWS_SEL_RESET 2'h3
`define RWS_SHORT_COUNT 18'h10000
`define RWS_LONG_COUNT 18'h20000
`define RWS_RESET_VECTOR 14'h0000
`endif

/* verilog/rws_pkg.sv */
// types of the reset and watchdog sequencer
package rws_pkg;
	typedef enum logic [1:0] {
		RWS_STOPPED = 2'h0,
		RWS_HALTED = 2'h1,
		RWS_RUNNING = 2'h3,
		RWS_CLKSTOP = 2'h2
	} rws_state_t;
	typedef struct packed {
		logic [2:0] sup_sync;
		logic [2:0] lo_sync;
		logic [2:0] rst_sync;
		logic [2:0] ce_sync;
		logic [2:0] wak_sync;
		logic [2:0] carry_sync;
		rws_state_t state;
		logic [31:0] halt_cnt;
		logic [17:0] dog_cnt;
		logic [1:0] interval_sel;
		logic sel_written;
		logic cause_flag;
		logic ce_pending;
		logic wake_window;
		logic [7:0] rdata;
		logic core_reset;
		logic osc_en;
		logic core_halt;
		logic start_pulse;
		logic power_clear;
		logic regs_init;
	} rws_regs_t;
endpackage : rws_pkg

/* verilog/rws_sequencer.sv */
// reset sequencer with watchdog, stack fault reset and reset-cause flag
// How it works
// - in clock stop, low supply at lower threshold asserts power clear, halts all
// - after power clear release hold core 50 ms, then start at 0000H
// - supply rising from zero enables oscillator at once, execution waits 50 ms
// - supply and enable rising together give one power-on start at 0000H
// - enable rising during forced halt adds no second start
// - enable rising after start restarts at 0000H on next carry edge
// - clock stop wakeup sets normal threshold at once; first carry edge after wakeup acts as enable reset
// - low reset pin stops oscillator, halts core, initializes all state
// - reset pin high restarts oscillator; start at address 0 after 50 ms
// - watchdog frozen in clock stop and halt
// - watchdog or stack reset spares interval, restart, carry and ce counter
// - watchdog or stack reset sets cause flag; reading it clears it
// - interval select writable once after power-on or pin reset
// - interval code 00 off, 01 65536, 10 prohibited, 11 131072; bit3 reads zero
// - interval select resets to 131072 on supply application
// - writing 1 to restart bit clears the watchdog counter
// - interrupt or address stack overflow or underflow causes a reset
// - watchdog expiry resets and resumes at address 0
`timescale 1ns/100ps
`include "rws_cfg.svh"
module rws_sequencer
	import rws_pkg::*;
#(
	parameter int HALT_CYCLES = `RWS_HALT_CYC
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic SUPPLY_OK,
	input wire logic SUPPLY_LOW_OK,
	input wire logic EXT_RESET_N,
	input wire logic CE_PIN,
	input wire logic WAKEUP_INT,
	input wire logic WAKEUP_PORT_INPUT,
	input wire logic CARRY_SET,
	input wire logic STOP_REQ,
	input wire logic HALT_MODE,
	input wire logic INSTR_DONE,
	input wire logic ISTACK_FAULT,
	input wire logic ASTACK_FAULT,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic CORE_RESET,
	output logic OSC_EN,
	output logic CORE_HALT,
	output logic START_PULSE,
	output logic POWER_CLEAR_SIGNAL,
	output logic REGS_INIT
);
	rws_regs_t q, d;

	// interval code to terminal count, zero means the watchdog is off
	function automatic logic [17:0] rws_limit(input logic [1:0] sel);
		if (sel == 2'h1) begin
			return `RWS_SHORT_COUNT;
		end else if (sel == 2'h3) begin
			return `RWS_LONG_COUNT;
		end else begin
			return 18'h00000;
		end
	endfunction : rws_limit

	// restarting the core: dog counter cleared
	function automatic logic [17:0] rws_zero();
		return 18'h00000;
	endfunction : rws_zero

	logic sup, lo, rst, wak, carry_rise, ce_rise;
	logic dog_fire, stack_fire, cold, threshold_ok;
	logic [17:0] lim;

	always_comb begin
		d = q;
		// pins are outside the clock domain: two flops before use
		d.sup_sync = {q.sup_sync[1:0], SUPPLY_OK};
		d.lo_sync = {q.lo_sync[1:0], SUPPLY_LOW_OK};
		d.rst_sync = {q.rst_sync[1:0], EXT_RESET_N};
		d.ce_sync = {q.ce_sync[1:0], CE_PIN};
		d.wak_sync = {q.wak_sync[1:0], WAKEUP_INT | WAKEUP_PORT_INPUT};
		d.carry_sync = {q.carry_sync[1:0], CARRY_SET};
		sup = q.sup_sync[1];
		lo = q.lo_sync[1];
		rst = q.rst_sync[1];
		wak = q.wak_sync[1];
		carry_rise = q.carry_sync[1] & ~q.carry_sync[2];
		ce_rise = q.ce_sync[1] & ~q.ce_sync[2];
		d.start_pulse = 1'b0;
		d.regs_init = 1'b0;
		d.rdata = 8'h00;
		lim = rws_limit(q.interval_sel);
		dog_fire = 1'b0;
		stack_fire = (ISTACK_FAULT | ASTACK_FAULT) & (q.state == RWS_RUNNING);
		// clock stop uses the lower threshold except during the wake window
		threshold_ok = (q.state == RWS_CLKSTOP && !q.wake_window) ? lo : sup;
		cold = !threshold_ok || !rst;
		// watchdog advances only on executed instructions while running
		if (q.state == RWS_RUNNING && !HALT_MODE) begin
			if (lim != 18'h00000 && INSTR_DONE) begin
				if (q.dog_cnt + 18'h00001 >= lim) begin
					dog_fire = 1'b1;
				end else begin
					d.dog_cnt = q.dog_cnt + 18'h00001;
				end
			end
		end
		// register writes
		if (WR) begin
			if (ADDR == `RWS_OFF_INTERVAL) begin
				if (!q.sel_written) begin
					d.interval_sel = {WDATA[`RWS_SEL_HI_BIT],
						WDATA[`RWS_SEL_LO_BIT]};
					d.sel_written = 1'b1;
				end
			end else if (ADDR == `RWS_OFF_RESTART) begin
				if (WDATA[0]) begin
					d.dog_cnt = rws_zero();
				end
			end
		end
		// register reads, data one cycle later; cause flag cleared by read
		if (RD) begin
			if (ADDR == `RWS_OFF_INTERVAL) begin
				d.rdata = {6'h00, q.interval_sel};
			end else if (ADDR == `RWS_OFF_CAUSE) begin
				d.rdata = {7'h00, q.cause_flag};
				d.cause_flag = 1'b0;
			end else if (ADDR == `RWS_OFF_STATUS) begin
				d.rdata = {5'h00, q.sel_written, q.state};
			end else begin
				d.rdata = 8'h00;
			end
		end
		// sequencer
		case (q.state)
			RWS_STOPPED: begin
				d.osc_en = 1'b0;
				d.core_halt = 1'b1;
				d.core_reset = 1'b1;
				d.halt_cnt = 32'h0;
				d.ce_pending = 1'b0;
				if (!cold) begin
					d.power_clear = 1'b0;
					d.osc_en = 1'b1;
					d.state = RWS_HALTED;
				end
			end
			RWS_HALTED: begin
				// enable edges here fold into the pending start
				if (q.halt_cnt < HALT_CYCLES) begin
					d.halt_cnt = q.halt_cnt + 32'h1;
				end else if (carry_rise || q.ce_pending) begin
					d.state = RWS_RUNNING;
					d.core_halt = 1'b0;
					d.core_reset = 1'b0;
					d.start_pulse = 1'b1;
					d.ce_pending = 1'b0;
					d.dog_cnt = rws_zero();
				end
			end
			RWS_RUNNING: begin
				if (ce_rise) begin
					d.ce_pending = 1'b1;
				end
				if (q.ce_pending && carry_rise) begin
					d.start_pulse = 1'b1;
					d.ce_pending = 1'b0;
					d.dog_cnt = rws_zero();
				end
				if (dog_fire || stack_fire) begin
					d.cause_flag = 1'b1;
					d.regs_init = 1'b1;
					d.start_pulse = 1'b1;
					d.dog_cnt = rws_zero();
				end
				if (STOP_REQ) begin
					d.state = RWS_CLKSTOP;
					d.osc_en = 1'b0;
					d.core_halt = 1'b1;
				end
			end
			RWS_CLKSTOP: begin
				if (wak && !q.wake_window) begin
					d.osc_en = 1'b1;
					d.wake_window = 1'b1;
					d.halt_cnt = 32'h0;
				end else if (q.wake_window) begin
					// tset/2 taken as the first carry edge after wakeup
					if (carry_rise) begin
						d.wake_window = 1'b0;
						d.state = RWS_HALTED;
						d.ce_pending = 1'b1;
						d.halt_cnt = HALT_CYCLES;
					end
				end
			end
			default: d.state = RWS_STOPPED;
		endcase
		// supply loss or reset pin wins over everything
		if (cold) begin
			d.state = RWS_STOPPED;
			d.power_clear = !threshold_ok;
			d.osc_en = 1'b0;
			d.core_halt = 1'b1;
			d.core_reset = 1'b1;
			d.regs_init = 1'b1;
			d.dog_cnt = rws_zero();
			d.wake_window = 1'b0;
			d.ce_pending = 1'b0;
			d.interval_sel = `RWS_SEL_RESET;
			d.sel_written = 1'b0;
			// power-on and pin reset both clear the cause flag
			d.cause_flag = 1'b0;
		end
	end

	// whole state registered in one place
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= '0;
			q.state <= RWS_STOPPED;
			q.interval_sel <= `RWS_SEL_RESET;
			q.core_reset <= 1'b1;
			q.core_halt <= 1'b1;
			q.power_clear <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign RDATA = q.rdata;
	assign CORE_RESET = q.core_reset;
	assign OSC_EN = q.osc_en;
	assign CORE_HALT = q.core_halt;
	assign START_PULSE = q.start_pulse;
	assign POWER_CLEAR_SIGNAL = q.power_clear;
	assign REGS_INIT = q.regs_init;
endmodule : rws_sequencer

/* testbench/rws_core_model.sv */
// core and base timer stand-in facing the sequencer
`timescale 1ns/100ps
module rws_core_model #(
	parameter int CARRY_HALF = 16
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CORE_HALT,
	input wire logic CORE_RESET,
	output logic CARRY_SET,
	output logic INSTR_DONE
);
	int cnt_q;
	// carry toggles freely; the core retires one instruction per running cycle
	// and never restarts the watchdog on its own
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_q <= 0;
			CARRY_SET <= 1'b0;
			INSTR_DONE <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == CARRY_HALF - 1) ? 0 : cnt_q + 1;
			CARRY_SET <= (cnt_q == CARRY_HALF - 1) ? !CARRY_SET : CARRY_SET;
			INSTR_DONE <= !CORE_HALT && !CORE_RESET;
		end
	end
endmodule : rws_core_model

/* testbench/rws_sequencer_monitor.sv */
// assertions on the sequencer ports
`timescale 1ns/100ps
module rws_sequencer_monitor (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic SUPPLY_LOW_OK,
	input wire logic EXT_RESET_N,
	input wire logic ISTACK_FAULT,
	input wire logic ASTACK_FAULT,
	input wire logic [3:0] ADDR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic OSC_EN,
	input wire logic CORE_HALT,
	input wire logic START_PULSE,
	input wire logic POWER_CLEAR_SIGNAL,
	input wire logic REGS_INIT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// five cycles leave room for the two synchroniser flops
	chk_low_supply_clear: assert property (!SUPPLY_LOW_OK [*5] |->
		POWER_CLEAR_SIGNAL && CORE_HALT) else $error("no clear on low supply");
	chk_start_single: assert property (START_PULSE |=> !START_PULSE)
		else $error("start pulse too long");
	chk_start_osc_on: assert property (START_PULSE |->
		OSC_EN && !POWER_CLEAR_SIGNAL) else $error("start without clock");
	chk_pin_reset_stop: assert property (!EXT_RESET_N [*5] |->
		!OSC_EN && CORE_HALT) else $error("pin reset did not stop");
	chk_cause_read_bits: assert property (RD && ADDR == 4'h4 |=>
		RDATA[7:1] == 7'h00) else $error("cause read upper bits");
	chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read slot");
	chk_sel_upper_zero: assert property (RD && ADDR == 4'h2 |=>
		RDATA[7:2] == 6'h00) else $error("interval upper bits set");
	chk_stack_reset: assert property ((ISTACK_FAULT || ASTACK_FAULT) &&
		!CORE_HALT |-> ##[1:4] REGS_INIT) else $error("stack fault ignored");
endmodule : rws_sequencer_monitor
bind rws_sequencer rws_sequencer_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N),
	.SUPPLY_LOW_OK(SUPPLY_LOW_OK), .EXT_RESET_N(EXT_RESET_N),
	.ISTACK_FAULT(ISTACK_FAULT), .ASTACK_FAULT(ASTACK_FAULT), .ADDR(ADDR),
	.RD(RD), .RDATA(RDATA), .OSC_EN(OSC_EN), .CORE_HALT(CORE_HALT),
	.START_PULSE(START_PULSE), .POWER_CLEAR_SIGNAL(POWER_CLEAR_SIGNAL),
	.REGS_INIT(REGS_INIT));

/* testbench/tb_top.sv */
// self-checking bench of the reset and watchdog sequencer
`timescale 1ns/100ps
module tb_top;
	logic CLK, RESET_N, SUPPLY_OK, SUPPLY_LOW_OK, EXT_RESET_N, CE_PIN;
	logic CARRY_SET, INSTR_DONE, ISTACK_FAULT, ASTACK_FAULT, WR, RD;
	logic STOP_REQ, HALT_MODE, WAKEUP_INT, WAKEUP_PORT_INPUT;
	logic [3:0] ADDR;
	logic [7:0] WDATA, RDATA;
	logic CORE_RESET, OSC_EN, CORE_HALT, START_PULSE, POWER_CLEAR_SIGNAL;
	logic rd_seen;
	logic [31:0] seed;
	logic [7:0] exp_q[$];
	int errors, checks_done, starts, s0;
	rws_sequencer #(.HALT_CYCLES(20)) u_dut (.CLK(CLK), .RESET_N(RESET_N),
		.SUPPLY_OK(SUPPLY_OK), .SUPPLY_LOW_OK(SUPPLY_LOW_OK),
		.EXT_RESET_N(EXT_RESET_N), .CE_PIN(CE_PIN), .WAKEUP_INT(WAKEUP_INT),
		.WAKEUP_PORT_INPUT(WAKEUP_PORT_INPUT), .CARRY_SET(CARRY_SET),
		.STOP_REQ(STOP_REQ), .HALT_MODE(HALT_MODE),
		.INSTR_DONE(INSTR_DONE), .ISTACK_FAULT(ISTACK_FAULT),
		.ASTACK_FAULT(ASTACK_FAULT), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .CORE_RESET(CORE_RESET), .OSC_EN(OSC_EN),
		.CORE_HALT(CORE_HALT), .START_PULSE(START_PULSE),
		.POWER_CLEAR_SIGNAL(POWER_CLEAR_SIGNAL), .REGS_INIT());
	rws_core_model u_core (.CLK(CLK), .RESET_N(RESET_N), .CORE_HALT(CORE_HALT),
		.CORE_RESET(CORE_RESET), .CARRY_SET(CARRY_SET), .INSTR_DONE(INSTR_DONE));
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = !CLK;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	// the expected value is noted now, the read checker below compares it two cycles later
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		exp_q.push_back(e);
		@(posedge CLK);
		RD <= 1'b0;
	endtask : rd
	task automatic wait_start(input int lim);
		int n;
		n = 0;
		while (START_PULSE !== 1'b1 && n < lim) begin
			@(posedge CLK);
			n++;
		end
		check({7'h00, START_PULSE}, 8'h01);
		@(posedge CLK);
	endtask : wait_start
	// read data stands only in the cycle after the strobe
	always @(posedge CLK) begin
		if (rd_seen === 1'b1) check(RDATA, exp_q.pop_front());
		rd_seen <= RD;
		if (START_PULSE === 1'b1) starts++;
	end
	initial begin
		{SUPPLY_OK, SUPPLY_LOW_OK, CE_PIN, ISTACK_FAULT, ASTACK_FAULT} = 5'h00;
		{STOP_REQ, HALT_MODE, WAKEUP_INT, WAKEUP_PORT_INPUT} = 4'h0;
		{WR, RD, rd_seen, RESET_N, EXT_RESET_N} = 5'h01;
		{ADDR, WDATA, errors, checks_done, starts} = '0;
		seed = 32'hf21ca576;
		repeat (10) @(posedge CLK);
		RESET_N <= 1'b1;
		// supply and enable pin rise together
		@(posedge CLK);
		{SUPPLY_OK, SUPPLY_LOW_OK, CE_PIN} <= 3'h7;
		wait_start(400);
		repeat (100) @(posedge CLK);
		check(8'(starts), 8'h01);
		CE_PIN <= 1'b0;
		repeat (5) @(posedge CLK);
		CE_PIN <= 1'b1;
		wait_start(100);
		// clock stop, then wake through the port: one start via enable reset
		STOP_REQ <= 1'b1;
		@(posedge CLK);
		STOP_REQ <= 1'b0;
		repeat (4) @(posedge CLK);
		check({6'h00, OSC_EN, CORE_HALT}, 8'h01);
		WAKEUP_PORT_INPUT <= 1'b1;
		wait_start(200);
		WAKEUP_PORT_INPUT <= 1'b0;
		seed = xs(seed);
		wr(4'he, seed[7:0]);
		rd(4'hf, 8'h00);
		rd(4'h4, 8'h00);
		wr(4'h2, 8'h01);
		wr(4'h2, 8'h00);
		@(posedge CLK);
		ASTACK_FAULT <= 1'b1;
		@(posedge CLK);
		ASTACK_FAULT <= 1'b0;
		wait_start(200);
		rd(4'h4, 8'h01);
		rd(4'h4, 8'h00);
		// interval kept through the stack reset, so the short count applies;
		// a halt spell first must not be counted by the watchdog
		s0 = starts;
		HALT_MODE <= 1'b1;
		repeat (2000) @(posedge CLK);
		HALT_MODE <= 1'b0;
		repeat (64000) @(posedge CLK);
		check(8'(starts), 8'(s0));
		wait_start(5000);
		rd(4'h4, 8'h01);
		EXT_RESET_N <= 1'b0;
		repeat (6) @(posedge CLK);
		check({6'h00, OSC_EN, CORE_HALT}, 8'h01);
		EXT_RESET_N <= 1'b1;
		wait_start(200);
		{SUPPLY_OK, SUPPLY_LOW_OK} <= 2'h0;
		repeat (6) @(posedge CLK);
		check({7'h00, POWER_CLEAR_SIGNAL}, 8'h01);
		close_out();
	end
	initial begin
		#800000;
		errors++;
		close_out();
	end
endmodule : tb_top
